// *** design/wor_option_reg.sv ***
// Write-once system option register with an AXI4-Lite slave and undervoltage monitor.
`timescale 1ns/1ns
module wor_option_reg
  import wor_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  output wire logic [1:0]        s_axi_bresp,
  output wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  output wire logic [DATA_W-1:0] s_axi_rdata,
  output wire logic [1:0]        s_axi_rresp,
  output wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              low_supply_pin,
  output wire logic              pwm_edge_align,
  output wire logic              low_side_polarity,
  output wire logic              high_side_polarity,
  output wire logic              output_pairing_select,
  output wire logic              undervoltage_monitor_power,
  output wire logic              watchdog_disable,
  output wire logic              undervoltage_reset
);

  // All state of the register bank and its bus slave.
  typedef struct packed {
    wor_opt_t          opt;
    logic              written;
    logic              aw_rdy;
    logic              w_rdy;
    logic              aw_have;
    logic              w_have;
    logic [5:0]        aw_idx;
    logic [7:0]        w_byte;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              ar_rdy;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } wor_regs_t;

  localparam wor_regs_t REGS_RST = '{
    opt:     wor_opt_t'(OPT_RESET),
    written: 1'b0,
    aw_rdy:  1'b1,
    w_rdy:   1'b1,
    aw_have: 1'b0,
    w_have:  1'b0,
    aw_idx:  6'h00,
    w_byte:  8'h00,
    w_lane0: 1'b0,
    bvalid:  1'b0,
    bresp:   RESP_OKAY,
    ar_rdy:  1'b1,
    rvalid:  1'b0,
    rdata:   32'h0000_0000,
    rresp:   RESP_OKAY
  };

  wor_regs_t q;
  wor_regs_t d;
  logic      uv_hold;

  // Handshakes on the AW, W and AR channels, and both write halves held.
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_go;

  assign aw_fire = s_axi_awvalid && q.aw_rdy;
  assign w_fire  = s_axi_wvalid && q.w_rdy;
  assign ar_fire = s_axi_arvalid && q.ar_rdy;
  assign wr_go   = q.aw_have && q.w_have;

  // Next state: bus channels, write-once store and read decode.
  always_comb begin
    d = q;

    // Take the write address; hold it until the response is accepted.
    if (aw_fire) begin
      d.aw_have = 1'b1;
      d.aw_rdy  = 1'b0;
      d.aw_idx  = s_axi_awaddr[ADDR_W-1:2];
    end

    // Take the write data; only the low byte lane matters.
    if (w_fire) begin
      d.w_have  = 1'b1;
      d.w_rdy   = 1'b0;
      d.w_byte  = s_axi_wdata[7:0];
      d.w_lane0 = s_axi_wstrb[0];
    end

    // Both halves present: perform the write and raise the response.
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = RESP_OKAY;
      if (q.aw_idx == OPT_IDX) begin
        // Later writes are answered normally but change nothing.
        if (!q.written && q.w_lane0) begin
          d.opt     = wor_opt_t'(q.w_byte);
          d.written = 1'b1;
        end
      end else if (q.aw_idx == STAT_IDX) begin
        d.bresp = RESP_OKAY; // Status is read-only; writes are dropped.
      end else begin
        d.bresp = RESP_DECERR;
      end
    end

    // Response accepted: reopen both write channels.
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.aw_rdy = 1'b1;
      d.w_rdy  = 1'b1;
    end

    // Read address taken: return data on the next cycle.
    if (ar_fire) begin
      d.ar_rdy = 1'b0;
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h0000_0000;
      if (s_axi_araddr[ADDR_W-1:2] == OPT_IDX) begin
        d.rdata[7:0] = q.opt;
      end else if (s_axi_araddr[ADDR_W-1:2] == STAT_IDX) begin
        d.rdata[STAT_WRITTEN_BIT] = q.written;
        d.rdata[STAT_HOLD_BIT]    = uv_hold;
      end else begin
        d.rresp = RESP_DECERR;
      end
    end

    // Read data accepted: reopen the read address channel.
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.ar_rdy = 1'b1;
    end
  end

  // Register the state; reset clears every option bit and the written flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // Bus outputs come straight from the state register.
  assign s_axi_awready = q.aw_rdy;
  assign s_axi_wready  = q.w_rdy;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.ar_rdy;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  // Option controls to the motor PWM, monitor and watchdog.
  assign pwm_edge_align             = q.opt.edge_align;
  assign low_side_polarity          = q.opt.low_side_polarity;
  assign high_side_polarity         = q.opt.high_side_polarity;
  assign output_pairing_select      = q.opt.output_pairing_select;
  assign undervoltage_monitor_power = q.opt.undervoltage_monitor_power;
  assign watchdog_disable           = q.opt.watchdog_disable;

  // Undervoltage filter; its reset request is gated by both enables.
  wor_uv_monitor u_uv_monitor (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .low_supply_pin (low_supply_pin),
    .monitor_power  (q.opt.undervoltage_monitor_power),
    .reset_enable   (q.opt.undervoltage_reset_enable),
    .reset_request  (uv_hold)
  );

  assign undervoltage_reset = uv_hold;

  // Helper: a write that lands on the option register with lane 0 enabled.
  logic opt_write_now;
  assign opt_write_now = wr_go && (q.aw_idx == OPT_IDX) && q.w_lane0;

  // Helpers: the write that uses up the single allowed write, and the index of a read request.
  logic       opt_first_write;
  logic [5:0] ar_idx;
  assign opt_first_write = opt_write_now && !q.written;
  assign ar_idx          = s_axi_araddr[ADDR_W-1:2];

  // Once written, the option bits never change until reset.
  a_opt_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    q.written |=> $stable(q.opt))
    else $error("Option bits changed after the single write.");

  // The first write stores the low data byte and sets the flag.
  a_first_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (opt_write_now && !q.written) |=> (q.written && (q.opt == $past(q.w_byte))))
    else $error("First option write not stored.");

  // The written flag is sticky until reset.
  a_written_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    q.written |=> q.written)
    else $error("Written flag cleared without reset.");

  // Reset clears the option bits and the flag.
  a_reset_clears: assert property (@(posedge aclk)
    !aresetn |=> ((q.opt == wor_opt_t'(OPT_RESET)) && !q.written))
    else $error("Reset did not clear the option register.");

  // A read of the option register returns its contents the next cycle.
  a_read_option: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_fire && (s_axi_araddr[ADDR_W-1:2] == OPT_IDX))
      |=> (s_axi_rvalid && (s_axi_rdata == {24'h00_0000, $past(q.opt)}) && (s_axi_rresp == RESP_OKAY)))
    else $error("Option read returned wrong data.");

  // Until the write happens every control sits at its zero setting.
  a_defaults_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !q.written |-> ({pwm_edge_align, low_side_polarity, high_side_polarity, output_pairing_select,
                     undervoltage_monitor_power, watchdog_disable} == 6'h00))
    else $error("Option control active before the register was written.");

  // The watchdog disable output tracks its stored bit across a write.
  a_watchdog_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (opt_write_now && !q.written) |=> (watchdog_disable == $past(q.w_byte[0])))
    else $error("Watchdog disable output does not follow the stored bit.");

  // The write response holds until accepted.
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("Write response dropped before acceptance.");

  // The edge alignment pin takes bit 7 of the first stored byte.
  a_edge_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    opt_first_write |=> (pwm_edge_align == $past(q.w_byte[7])))
    else $error("Edge alignment output does not follow bit 7.");

  // The low-side polarity pin takes bit 6.
  a_low_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    opt_first_write |=> (low_side_polarity == $past(q.w_byte[6])))
    else $error("Low-side polarity output does not follow bit 6.");

  // The high-side polarity pin takes bit 5.
  a_high_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    opt_first_write |=> (high_side_polarity == $past(q.w_byte[5])))
    else $error("High-side polarity output does not follow bit 5.");

  // The output pairing pin takes bit 4.
  a_pair_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    opt_first_write |=> (output_pairing_select == $past(q.w_byte[4])))
    else $error("Output pairing select does not follow bit 4.");

  // The undervoltage reset enable is stored from bit 3.
  a_uv_enable_stored: assert property (@(posedge aclk) disable iff (!aresetn)
    opt_first_write |=> (q.opt.undervoltage_reset_enable == $past(q.w_byte[3])))
    else $error("Undervoltage reset enable not stored from bit 3.");

  // The monitor power pin takes bit 2.
  a_power_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    opt_first_write |=> (undervoltage_monitor_power == $past(q.w_byte[2])))
    else $error("Monitor power output does not follow bit 2.");

  // The halt enable is stored from bit 1 and drives no pin.
  a_halt_stored: assert property (@(posedge aclk) disable iff (!aresetn)
    opt_first_write |=> (q.opt.halt_enable == $past(q.w_byte[1])))
    else $error("Halt enable not stored from bit 1.");

  // Outside the first write the option bits never move.
  a_opt_only_first: assert property (@(posedge aclk) disable iff (!aresetn)
    !opt_first_write |=> $stable(q.opt))
    else $error("Option bits changed without a first write.");

  // A write without lane 0 neither stores nor uses up the single write.
  a_lane_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && (q.aw_idx == OPT_IDX) && !q.w_lane0) |=> ($stable(q.opt) && $stable(q.written)))
    else $error("Option write without lane 0 had an effect.");

  // The written flag is only ever set by a stored write.
  a_written_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.written) |-> $past(opt_first_write))
    else $error("Written flag set without an option write.");

  // Later writes are answered normally and leave the bits alone.
  a_later_write_okay: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && (q.aw_idx == OPT_IDX) && q.written)
      |=> (s_axi_bvalid && (s_axi_bresp == RESP_OKAY) && $stable(q.opt)))
    else $error("Later option write not answered normally.");

  // The status word reports the written flag and the undervoltage hold.
  a_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_fire && (ar_idx == STAT_IDX)) |=> (s_axi_rdata == {30'h0, $past(uv_hold), $past(q.written)}))
    else $error("Status read returned wrong data.");

  // A read outside the map is refused with zero data.
  a_decode_error: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_fire && (ar_idx != OPT_IDX) && (ar_idx != STAT_IDX))
      |=> ((s_axi_rresp == RESP_DECERR) && (s_axi_rdata == 32'h0000_0000)))
    else $error("Unmapped read not refused.");

  // A write outside the map is refused.
  a_write_decerr: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && (q.aw_idx != OPT_IDX) && (q.aw_idx != STAT_IDX)) |=> (s_axi_bresp == RESP_DECERR))
    else $error("Unmapped write not refused.");

  // Read data holds until accepted.
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("Read data dropped before acceptance.");

  // The write channels stay closed while a response is pending.
  a_aw_closed: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("Write channel open during a pending response.");

  // The read address channel stays closed while read data is pending.
  a_ar_closed: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("Read channel open during pending read data.");

  // A complete write is answered on the next cycle.
  a_bvalid_after_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("Write response missing after a complete write.");

  // The main scenarios.
  c_first_write: cover property (@(posedge aclk) disable iff (!aresetn) opt_write_now && !q.written);
  c_second_write: cover property (@(posedge aclk) disable iff (!aresetn) opt_write_now && q.written);
  c_read_option: cover property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && (s_axi_araddr[ADDR_W-1:2] == OPT_IDX));
  c_lane_skip: cover property (@(posedge aclk) disable iff (!aresetn) wr_go && (q.aw_idx == OPT_IDX) && !q.w_lane0);

endmodule : wor_option_reg

// *** design/wor_pkg.sv ***
// Package with the constants and types of the write-once option register block.
// Behaviour
// - Only first write after reset is stored; code stores the first one with byte lane 0 enabled.
// - Reset clears every option bit to zero.
// - Register decoded at index 1F, always readable.
// - Alignment bit one selects edge-aligned PWM.
// - Low-side polarity bit one means negative.
// - High-side polarity bit one means negative.
// - Pairing bit one gives six independent outputs.
// - Undervoltage reset enable passes monitor reset.
// - Monitor power bit powers the undervoltage monitor.
// - Halt enable stored write-once, no effect.
// - Watchdog disable bit one disables watchdog.
// - Trip only after nine consecutive low cycles.
// - Hold reset until low-supply indication clears.
// - Watchdog disable output follows stored bit.
package wor_pkg;

  // Bus geometry.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] OPT_IDX  = 6'h1F;
  localparam logic [5:0] STAT_IDX = 6'h20;

  // Reset value of the option register.
  localparam logic [7:0] OPT_RESET = 8'h00;

  // Status register field positions.
  localparam int unsigned STAT_WRITTEN_BIT = 0;
  localparam int unsigned STAT_HOLD_BIT    = 1;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Consecutive processor cycles of low supply needed before a trip.
  localparam logic [3:0] UV_TRIP_CYCLES = 4'h9;

  // Layout of the option register, bit 7 first.
  typedef struct packed {
    logic edge_align;
    logic low_side_polarity;
    logic high_side_polarity;
    logic output_pairing_select;
    logic undervoltage_reset_enable;
    logic undervoltage_monitor_power;
    logic halt_enable;
    logic watchdog_disable;
  } wor_opt_t;

endpackage : wor_pkg

// *** design/wor_uv_monitor.sv ***
// Undervoltage monitor filter that raises and holds the system reset request.
`timescale 1ns/1ns
module wor_uv_monitor
  import wor_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic low_supply_pin,
  input  wire logic monitor_power,
  input  wire logic reset_enable,
  output wire logic reset_request
);

  // All state of the filter.
  typedef struct packed {
    logic       sync_meta;
    logic       sync_low;
    logic [3:0] cnt;
    logic       hold;
  } wor_uv_state_t;

  localparam wor_uv_state_t UV_RST = '{sync_meta: 1'b0, sync_low: 1'b0, cnt: 4'h0, hold: 1'b0};

  wor_uv_state_t q;
  wor_uv_state_t d;

  // Synchronise the pin, count consecutive low cycles and hold the reset.
  always_comb begin
    d           = q;
    d.sync_meta = low_supply_pin;
    d.sync_low  = q.sync_meta;
    if (q.hold) begin
      d.cnt = 4'h0;
      if (!q.sync_low) begin
        d.hold = 1'b0;
      end
    end else if (monitor_power && reset_enable && q.sync_low) begin
      if (q.cnt == (UV_TRIP_CYCLES - 4'h1)) begin
        d.hold = 1'b1;
        d.cnt  = 4'h0;
      end else begin
        d.cnt = q.cnt + 4'h1;
      end
    end else begin
      d.cnt = 4'h0; // A single good cycle restarts the count.
    end
  end

  // Register the filter state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= UV_RST;
    end else begin
      q <= d;
    end
  end

  assign reset_request = q.hold;

  // The trip follows a full run of nine enabled low cycles.
  a_trip_on_nine: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.hold) |-> $past(monitor_power && reset_enable && q.sync_low, 1)
      && $past(monitor_power && reset_enable && q.sync_low, 9))
    else $error("Undervoltage trip without nine low cycles.");

  // No trip while either enable is off.
  a_trip_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    (!q.hold && !(monitor_power && reset_enable)) |=> !q.hold)
    else $error("Undervoltage trip while monitor or its reset is disabled.");

  // The hold stays while the supply is low and drops once it clears.
  a_hold_release: assert property (@(posedge aclk) disable iff (!aresetn)
    q.hold |=> (q.hold == $past(q.sync_low)))
    else $error("Undervoltage hold not tied to the low-supply indication.");

  // A trip is seen.
  c_uv_trip: cover property (@(posedge aclk) disable iff (!aresetn) $rose(q.hold));

endmodule : wor_uv_monitor

// *** verification/wor_option_reg_tb.sv ***
// Self-checking testbench for the write-once option register block.
`timescale 1ns/1ns
module wor_option_reg_tb;
  import wor_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0]        s_axi_awprot = '0, s_axi_arprot = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [3:0]        s_axi_wstrb = '0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, low_supply_pin = 1'b0, uv_seen = 1'b0, uv_clr = 1'b0;
  wire logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]   s_axi_bresp, s_axi_rresp;
  wire logic [31:0]  s_axi_rdata;
  wire logic         pwm_edge_align, low_side_polarity, high_side_polarity, output_pairing_select;
  wire logic         undervoltage_monitor_power, watchdog_disable, undervoltage_reset;
  int                n_fail = 0, n_tests = 0;

  wor_option_reg dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_supply_pin,
    .pwm_edge_align, .low_side_polarity, .high_side_polarity, .output_pairing_select,
    .undervoltage_monitor_power, .watchdog_disable, .undervoltage_reset
  );

  // Free-running 125 MHz clock.
  always #4 aclk = ~aclk;

  // Remembers any undervoltage reset request seen since the last clear.
  always @(posedge aclk) begin
    if (uv_clr) uv_seen <= 1'b0;
    else if (undervoltage_reset === 1'b1) uv_seen <= 1'b1;
  end

  task automatic test_done();
    $display("Comparisons: %0d, mismatches: %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // A handshake that never completes is counted and ends the run.
  task automatic hang_check(input int n);
    if (n > 40) begin
      chk("handshake_wait", 32'h1, 32'h0);
      test_done();
    end
  endtask : hang_check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    int   n;
    n = 0;
    b_hs = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid & s_axi_awready;
      w_hs  = s_axi_wvalid & s_axi_wready;
      b_hs  = s_axi_bvalid === 1'b1;
      if (b_hs) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) s_axi_bready <= 1'b0;
      n++;
      hang_check(n);
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_hs, r_hs;
    int   n;
    n = 0;
    r_hs = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid & s_axi_arready;
      r_hs  = s_axi_rvalid === 1'b1;
      if (r_hs) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      if (r_hs) chk("rdata", ed, s_axi_rdata);
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) s_axi_rready <= 1'b0;
      n++;
      hang_check(n);
    end
  endtask : axi_read

  // Compares the option pins against a register value; bits 3 and 1 have no pin.
  task automatic chk_opt(input logic [7:0] e);
    @(negedge aclk);
    chk("option_pins", {24'h0, e & 8'hF5}, {24'h0, pwm_edge_align, low_side_polarity, high_side_polarity,
        output_pairing_select, 1'b0, undervoltage_monitor_power, 1'b0, watchdog_disable});
    @(posedge aclk);
  endtask : chk_opt

  task automatic pin(input logic v, input int c);
    low_supply_pin <= v;
    repeat (c) @(posedge aclk);
  endtask : pin

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // Main sequence: write-once behaviour, decoding, option pins, undervoltage filter.
  initial begin
    int n;
    do_reset();
    axi_read(8'h7C, 32'h0, RESP_OKAY);
    chk_opt(8'h00);
    axi_write(8'h7C, 32'hFF, 4'h0, RESP_OKAY);
    axi_read(8'h7C, 32'h0, RESP_OKAY);
    axi_read(8'h80, 32'h0, RESP_OKAY);
    axi_write(8'h7C, 32'hFFFF_FFA5, 4'hF, RESP_OKAY);
    axi_read(8'h7C, 32'hA5, RESP_OKAY);
    chk_opt(8'hA5);
    axi_read(8'h80, 32'h1, RESP_OKAY);
    axi_write(8'h7C, 32'h5A, 4'hF, RESP_OKAY);
    axi_read(8'h7C, 32'hA5, RESP_OKAY);
    chk_opt(8'hA5);
    axi_read(8'h84, 32'h0, RESP_DECERR);
    axi_write(8'h40, 32'h1, 4'hF, RESP_DECERR);
    pin(1'b1, 20);
    @(negedge aclk);
    chk("uv_blocked", 32'h0, {31'h0, uv_seen});
    @(posedge aclk);
    pin(1'b0, 4);
    do_reset();
    axi_read(8'h7C, 32'h0, RESP_OKAY);
    axi_write(8'h7C, 32'h5E, 4'h1, RESP_OKAY);
    axi_read(8'h7C, 32'h5E, RESP_OKAY);
    chk_opt(8'h5E);
    uv_clr <= 1'b1;
    @(posedge aclk);
    uv_clr <= 1'b0;
    pin(1'b1, 8);
    pin(1'b0, 12);
    @(negedge aclk);
    chk("uv_short_dip", 32'h0, {31'h0, uv_seen});
    @(posedge aclk);
    pin(1'b1, 10);
    @(negedge aclk);
    chk("uv_early", 32'h0, {31'h0, uv_seen});
    n = 0;
    while (undervoltage_reset !== 1'b1 && n < 6) begin
      @(negedge aclk);
      n++;
    end
    chk("uv_trip", 32'h1, {31'h0, undervoltage_reset});
    axi_read(8'h80, 32'h3, RESP_OKAY);
    @(negedge aclk);
    chk("uv_hold", 32'h1, {31'h0, undervoltage_reset});
    @(posedge aclk);
    pin(1'b0, 8);
    @(negedge aclk);
    chk("uv_release", 32'h0, {31'h0, undervoltage_reset});
    test_done();
  end
endmodule : wor_option_reg_tb
